/* core/dtp_pkg.sv */
// Shared constants and carrier types for the down-count timer with pulse and buzzer outputs.
package dtp_pkg;

    // ==========================================================================
    // Register map (register index; byte address is four times the index)
    // ==========================================================================
    localparam int unsigned ADDR_W      = 5;
    localparam logic [2:0]  IDX_COUNT   = 3'h0;
    localparam logic [2:0]  IDX_CTRL1   = 3'h1;
    localparam logic [2:0]  IDX_CTRL2   = 3'h2;
    localparam logic [2:0]  IDX_DUTY    = 3'h3;
    localparam logic [2:0]  IDX_PRESC   = 3'h4;
    localparam logic [2:0]  IDX_BUZZ    = 3'h5;
    localparam logic [2:0]  IDX_STATUS  = 3'h6;

    // ==========================================================================
    // Values after reset
    // ==========================================================================
    localparam logic [7:0]  COUNT_RST   = 8'h00;
    localparam logic [7:0]  RELOAD_RST  = 8'h00;
    localparam logic [7:0]  CTRL1_RST   = 8'h00;
    localparam logic [7:0]  CTRL2_RST   = 8'h3f;
    localparam logic [7:0]  DUTY_RST    = 8'h00;
    localparam logic [7:0]  PRESC_RST   = 8'hff;
    localparam logic [7:0]  BUZZ_RST    = 8'h0f;

    // ==========================================================================
    // Counter constants and field positions
    // ==========================================================================
    localparam logic [7:0]  WRAP_VALUE  = 8'hff;
    localparam logic [7:0]  ZERO_COUNT  = 8'h00;
    localparam int unsigned STATUS_FLAG_BIT = 0;
    localparam int unsigned BYTE_LANE0  = 0;

    // ==========================================================================
    // Register layouts
    // ==========================================================================
    typedef struct packed {
        logic       out_en;
        logic       polarity;
        logic [2:0] unused;
        logic       one_shot;
        logic       reload_sel;
        logic       enable;
    } dtp_ctrl1_t;

    typedef struct packed {
        logic [1:0] unused;
        logic       clk_ext;
        logic       edge_fall;
        logic       presc_dis_n;
        logic [2:0] rate;
    } dtp_ctrl2_t;

    typedef struct packed {
        logic       enable;
        logic [2:0] unused;
        logic [3:0] tap;
    } dtp_buzz_t;

    // Request carried from the timer to its prescaler.
    typedef struct packed {
        logic       run;
        logic       src_tick;
        logic [2:0] rate;
    } dtp_presc_req_t;

endpackage : dtp_pkg

/* core/dtp_prescaler.sv */
// Power-of-two prescaler that divides the timer's source ticks.
module dtp_prescaler
    import dtp_pkg::*;
(
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           resetn_i,
    // Request from the timer
    input  wire dtp_presc_req_t req_i,
    // Prescaler state and divided tick
    output logic [7:0]          count_o,
    output logic                tick_o
);

    // ==========================================================================
    // Divider
    // ==========================================================================
    logic [7:0] count_q;

    // Low-bit mask for a rate code: code 0 divides by 2, code 7 by 256.
    function automatic logic [7:0] rate_mask(input logic [2:0] rate);
        rate_mask = WRAP_VALUE >> (3'd7 - rate);
    endfunction

    // A divided tick leaves when the masked low bits stand at zero as a source tick arrives.
    // Changing the rate while running can cut one period short; software avoids that.
    assign tick_o = req_i.run && req_i.src_tick
                    && ((count_q & rate_mask(req_i.rate)) == ZERO_COUNT);

    // The counter only moves while the timer runs it, so a stopped timer holds it.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= PRESC_RST;
        end else if (req_i.run && req_i.src_tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    assign count_o = count_q;

    // A divided tick also steps the counter, so its masked low bits wrap to all ones.
    a_tick_rate: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick_o |=> (count_q & rate_mask(req_i.rate)) == rate_mask(req_i.rate)
                   || $changed(req_i.rate))
        else $error("prescaler tick did not restart its phase");

endmodule : dtp_prescaler

/* core/dtp_timer.sv */
// Eight-bit down-count timer with pulse-width output, buzzer output and Avalon-MM registers.
module dtp_timer
    import dtp_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Avalon-MM register slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // Shared port pin
    input  wire logic              shared_pin_i,
    output logic                   shared_pin_o,
    output logic                   shared_pin_oe_o,
    // Port logic and pin option
    input  wire logic              gpio_out_i,
    input  wire logic              gpio_oe_i,
    input  wire logic              buzzer_pin_option_i,
    // Block outputs
    output logic                   pwm_o,
    output logic                   buzzer_o,
    output logic                   underflow_flag_o
);

    // ==========================================================================
    // Register state
    // ==========================================================================
    logic [7:0] count_value_q;
    logic [7:0] reload_q;
    dtp_ctrl1_t control_reg_one_q;
    dtp_ctrl2_t control_reg_two_q;
    logic [7:0] duty_value_q;
    dtp_buzz_t  buzzer_control_reg_q;
    logic       underflow_flag_q;
    logic       oneshot_done_q;
    logic       pwm_active_q;
    logic       frame_end_q;
    logic [7:0] prescaler_count_readback;
    logic       presc_tick;

    // ==========================================================================
    // Avalon-MM handshake
    // ==========================================================================
    logic [31:0] readdata_q;
    logic        waitrequest_q;
    logic [2:0]  reg_idx;
    logic        rd_take;
    logic        wr_acc;
    logic        wr_lane;

    assign reg_idx = avs_address_i[ADDR_W-1:2];
    assign rd_take = avs_read_i && waitrequest_q;
    assign wr_acc  = avs_write_i && !waitrequest_q;
    assign wr_lane = wr_acc && avs_byteenable_i[BYTE_LANE0];

    // Waitrequest drops for one cycle after a request appears, so every access takes two edges.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            waitrequest_q <= 1'b1;
        end else begin
            waitrequest_q <= !((avs_read_i || avs_write_i) && waitrequest_q);
        end
    end

    // Read data are captured on the first edge and stand while waitrequest is low.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            unique case (reg_idx)
                IDX_COUNT:  readdata_q <= {24'h00_0000, count_value_q};
                IDX_CTRL1:  readdata_q <= {29'h0000_0000, control_reg_one_q.one_shot,
                                           control_reg_one_q.reload_sel,
                                           control_reg_one_q.enable};
                IDX_CTRL2:  readdata_q <= {26'h000_0000, control_reg_two_q.clk_ext,
                                           control_reg_two_q.edge_fall,
                                           control_reg_two_q.presc_dis_n,
                                           control_reg_two_q.rate};
                IDX_PRESC:  readdata_q <= {24'h00_0000, prescaler_count_readback};
                IDX_BUZZ:   readdata_q <= {24'h00_0000, buzzer_control_reg_q.enable, 7'h00};
                IDX_STATUS: readdata_q <= {31'h0000_0000, underflow_flag_q};
                // The duty register and unmapped indexes read as zero.
                default:    readdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_o    = readdata_q;
    assign avs_waitrequest_o = waitrequest_q;

    // ==========================================================================
    // Configuration registers
    // ==========================================================================
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_reg_one_q <= dtp_ctrl1_t'(CTRL1_RST);
        end else if (wr_lane && reg_idx == IDX_CTRL1) begin
            control_reg_one_q <= dtp_ctrl1_t'(avs_writedata_i[7:0]);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_reg_two_q <= dtp_ctrl2_t'(CTRL2_RST);
        end else if (wr_lane && reg_idx == IDX_CTRL2) begin
            control_reg_two_q <= dtp_ctrl2_t'(avs_writedata_i[7:0]);
        end
    end

    // Duty is stored for the comparator only; no read path exists.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            duty_value_q <= DUTY_RST;
        end else if (wr_lane && reg_idx == IDX_DUTY) begin
            duty_value_q <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buzzer_control_reg_q <= dtp_buzz_t'(BUZZ_RST);
        end else if (wr_lane && reg_idx == IDX_BUZZ) begin
            buzzer_control_reg_q <= dtp_buzz_t'(avs_writedata_i[7:0]);
        end
    end

    // ==========================================================================
    // External clock pin synchroniser and edge detect
    // ==========================================================================
    logic ext_sync1_q;
    logic ext_sync2_q;
    logic ext_prev_q;
    logic ext_edge;
    logic src_tick;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_sync1_q <= 1'b0;
            ext_sync2_q <= 1'b0;
            ext_prev_q  <= 1'b0;
        end else begin
            ext_sync1_q <= shared_pin_i;
            ext_sync2_q <= ext_sync1_q;
            ext_prev_q  <= ext_sync2_q;
        end
    end

    // Edge polarity comes from the edge bit; the pin is two cycles late after syncing.
    assign ext_edge = control_reg_two_q.edge_fall ? (ext_prev_q && !ext_sync2_q)
                                                  : (!ext_prev_q && ext_sync2_q);
    // The instruction clock is the system clock itself, so it ticks every cycle.
    assign src_tick = control_reg_two_q.clk_ext ? ext_edge : 1'b1;

    // ==========================================================================
    // Prescaler
    // ==========================================================================
    dtp_presc_req_t presc_req;
    logic           dec_tick;
    logic           underflow;

    assign presc_req.run      = control_reg_one_q.enable && !control_reg_two_q.presc_dis_n;
    assign presc_req.src_tick = src_tick;
    assign presc_req.rate     = control_reg_two_q.rate;

    dtp_prescaler u_prescaler (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .req_i    (presc_req),
        .count_o  (prescaler_count_readback),
        .tick_o   (presc_tick)
    );

    // With the prescaler disabled each source tick reaches the counter directly.
    assign dec_tick  = control_reg_one_q.enable && !oneshot_done_q
                       && (control_reg_two_q.presc_dis_n ? src_tick : presc_tick);
    assign underflow = dec_tick && (count_value_q == ZERO_COUNT);

    // ==========================================================================
    // Down counter
    // ==========================================================================
    // A bus write wins over a tick in the same cycle so software sees its value land.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_value_q <= COUNT_RST;
            reload_q      <= RELOAD_RST;
        end else if (wr_lane && reg_idx == IDX_COUNT) begin
            count_value_q <= avs_writedata_i[7:0];
            reload_q      <= avs_writedata_i[7:0];
        end else if (underflow) begin
            if (control_reg_one_q.one_shot) begin
                count_value_q <= ZERO_COUNT;
            end else if (control_reg_one_q.reload_sel) begin
                count_value_q <= reload_q;
            end else begin
                count_value_q <= WRAP_VALUE;
            end
        end else if (dec_tick) begin
            count_value_q <= count_value_q - 8'h01;
        end
    end

    // One-shot parks at zero until a count write or disabling the timer rearms it.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oneshot_done_q <= 1'b0;
        end else if ((wr_lane && reg_idx == IDX_COUNT) || !control_reg_one_q.enable) begin
            oneshot_done_q <= 1'b0;
        end else if (underflow && control_reg_one_q.one_shot) begin
            oneshot_done_q <= 1'b1;
        end
    end

    // Sticky flag; an underflow in the clearing cycle keeps it set.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            underflow_flag_q <= 1'b0;
        end else begin
            underflow_flag_q <= underflow || (underflow_flag_q && !(wr_lane
                && reg_idx == IDX_STATUS && avs_writedata_i[STATUS_FLAG_BIT]));
        end
    end

    // ==========================================================================
    // Pulse-width and buzzer waveforms
    // ==========================================================================
    // The reload value sets the frame and the duty match starts the active part, which lasts
    // through the zero count, ending one edge after the underflow edge; a match wins then.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_end_q  <= 1'b0;
            pwm_active_q <= 1'b0;
        end else begin
            frame_end_q  <= underflow;
            pwm_active_q <= control_reg_one_q.enable && ((count_value_q == duty_value_q)
                            || (pwm_active_q && !frame_end_q));
        end
    end

    logic pwm_level;
    logic buzz_src;

    assign pwm_level = pwm_active_q ^ control_reg_one_q.polarity;
    assign buzz_src  = buzzer_control_reg_q.tap[3]
                       ? count_value_q[buzzer_control_reg_q.tap[2:0]]
                       : prescaler_count_readback[buzzer_control_reg_q.tap[2:0]];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwm_o    <= 1'b0;
            buzzer_o <= 1'b0;
        end else begin
            pwm_o    <= pwm_level;
            buzzer_o <= buzzer_control_reg_q.enable && buzz_src;
        end
    end

    assign underflow_flag_o = underflow_flag_q;

    // ==========================================================================
    // Shared pin multiplexer
    // ==========================================================================
    // External clocking owns the pin first; driving it then would fight the clock source.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shared_pin_o    <= 1'b0;
            shared_pin_oe_o <= 1'b0;
        end else if (control_reg_two_q.clk_ext) begin
            shared_pin_o    <= 1'b0;
            shared_pin_oe_o <= 1'b0;
        end else if (control_reg_one_q.out_en) begin
            shared_pin_o    <= pwm_level;
            shared_pin_oe_o <= 1'b1;
        end else if (buzzer_control_reg_q.enable && buzzer_pin_option_i) begin
            shared_pin_o    <= buzzer_control_reg_q.enable && buzz_src;
            shared_pin_oe_o <= 1'b1;
        end else begin
            shared_pin_o    <= gpio_out_i;
            shared_pin_oe_o <= gpio_oe_i;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_count_write;
        wr_lane && reg_idx == IDX_COUNT;
    endsequence
    sequence s_idle_tick_at_zero;
        underflow && !(wr_lane && reg_idx == IDX_COUNT);
    endsequence

    a_count_write_load: assert property (
        s_count_write |=> count_value_q == $past(avs_writedata_i[7:0])
                          && reload_q == $past(avs_writedata_i[7:0]))
        else $error("count write did not load both registers");
    a_count_read_live: assert property (
        rd_take && reg_idx == IDX_COUNT |=> !avs_waitrequest_o
                                            && avs_readdata_o[7:0] == $past(count_value_q))
        else $error("count read did not return the live count");
    a_wrap_full_scale: assert property (
        s_idle_tick_at_zero ##0 (!control_reg_one_q.one_shot && !control_reg_one_q.reload_sel)
        |=> count_value_q == WRAP_VALUE)
        else $error("non-stop wrap did not restart at full scale");
    a_reload_restart: assert property (
        s_idle_tick_at_zero ##0 (!control_reg_one_q.one_shot && control_reg_one_q.reload_sel)
        |=> count_value_q == $past(reload_q))
        else $error("non-stop reload did not restart from the reload value");
    a_oneshot_parks: assert property (
        s_idle_tick_at_zero ##0 control_reg_one_q.one_shot
        ##1 (control_reg_one_q.enable && !(wr_lane && reg_idx == IDX_COUNT))
        |-> count_value_q == ZERO_COUNT && !dec_tick)
        else $error("one-shot kept counting after zero");
    a_pwm_frame_end: assert property (
        underflow ##1 (count_value_q != duty_value_q) |=> !pwm_active_q
            ##1 (pwm_o == control_reg_one_q.polarity
                 || $past(control_reg_one_q.polarity, 1) != control_reg_one_q.polarity))
        else $error("pulse stayed active past underflow");
    a_duty_reads_zero: assert property (
        rd_take && reg_idx == IDX_DUTY |=> avs_readdata_o == 32'h0000_0000)
        else $error("duty register returned data");
    a_flag_sticky: assert property (
        underflow |=> underflow_flag_o ##1 (underflow_flag_o
            || $past(wr_lane && reg_idx == IDX_STATUS && avs_writedata_i[STATUS_FLAG_BIT])))
        else $error("underflow flag not held");
    a_hold_disabled: assert property (
        !control_reg_one_q.enable [*2] ##0 !$past(wr_lane && reg_idx == IDX_COUNT)
        |-> $stable(count_value_q) && $stable(prescaler_count_readback))
        else $error("counter moved while disabled");
    a_ext_pin_input: assert property (
        control_reg_two_q.clk_ext |=> !shared_pin_oe_o)
        else $error("shared pin driven while used as clock input");

endmodule : dtp_timer

/* testbench/dtp_testbench.sv */
// Self-checking bench for the down-count timer with pulse and buzzer outputs.
module testbench
    import dtp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================================
    // Signals
    // ==========================================================================
    logic              clk_i, resetn_i, avs_read_i, avs_write_i, shared_pin_i;
    logic              gpio_out_i, gpio_oe_i, buzzer_pin_option_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [31:0]       avs_writedata_i, avs_readdata_o;
    logic [3:0]        avs_byteenable_i;
    logic              avs_waitrequest_o, shared_pin_o, shared_pin_oe_o;
    logic              pwm_o, buzzer_o, underflow_flag_o;
    logic [7:0]        q, v, p0, ex;
    int                error_cnt = 0, comparisons = 0, seed = 58227;
    int                w, k, act, bad, pn, dn;
    logic [7:0]        rst_exp [8] = '{COUNT_RST, CTRL1_RST, CTRL2_RST, 8'h00,
                                       PRESC_RST, 8'h00, 8'h00, 8'h00};
    logic [7:0]        modes [3] = '{8'h01, 8'h03, 8'h07};

    dtp_timer dut (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .shared_pin_i, .shared_pin_o, .shared_pin_oe_o, .gpio_out_i, .gpio_oe_i,
        .buzzer_pin_option_i, .pwm_o, .buzzer_o, .underflow_flag_o);

    // Free-running 50 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ==========================================================================
    // Helpers
    // ==========================================================================
    task automatic end_sim();
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Tolerance absorbs the unknown phase of a counter against the bus timing.
    function automatic logic near(int a, int b, int t);
        return (a - b <= t) && (b - a <= t);
    endfunction

    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic bus(input logic wr_en, input logic [2:0] idx, input logic [7:0] d);
        int n = 0;
        avs_address_i   <= {idx, 2'b00};
        avs_write_i     <= wr_en;
        avs_read_i      <= ~wr_en;
        avs_writedata_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin
                error_cnt++;
                end_sim();
            end
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Watchdog so that a hung design still reaches the verdict.
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end

    // ==========================================================================
    // Stimulus
    // ==========================================================================
    initial begin
        resetn_i = 1'b0;
        {avs_read_i, avs_write_i, shared_pin_i, gpio_out_i, gpio_oe_i} = '0;
        buzzer_pin_option_i = 1'b0;
        avs_address_i = '0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'h1;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            bus(0, 3'(i), 8'h00);
            chk(q, rst_exp[i]);
        end
        // A disabled lane must not land, and a stopped timer must hold.
        v = 8'($random(seed));
        bus(1, IDX_COUNT, v);
        avs_byteenable_i <= 4'h0;
        bus(1, IDX_COUNT, ~v);
        avs_byteenable_i <= 4'h1;
        bus(1, IDX_DUTY, v);
        tick(20);
        bus(0, IDX_COUNT, 8'h00);
        chk(q, v);
        bus(0, IDX_DUTY, 8'h00);
        chk(q, 8'h00);
        // Wrap, reload and one-shot from a short count.
        bus(1, IDX_CTRL2, 8'h08);
        for (int m = 0; m < 3; m++) begin
            bus(1, IDX_COUNT, 8'h03);
            bus(1, IDX_CTRL1, modes[m]);
            tick(10 + ($random(seed) & 7));
            bus(1, IDX_CTRL1, 8'h00);
            bus(0, IDX_COUNT, 8'h00);
            if (m == 0) chk(q >= 8'he0, 1);
            if (m == 1) chk(q <= 8'h03, 1);
            if (m == 2) chk(q, 8'h00);
            bus(0, IDX_STATUS, 8'h00);
            chk(q, 8'h01);
            bus(1, IDX_STATUS, 8'h01);
            chk(underflow_flag_o, 1'b0);
        end
        // Every rate code, then the prescaler bypassed.
        for (int r = 0; r < 9; r++) begin
            bus(1, IDX_CTRL2, 8'h08 | 8'(r));
            if (r < 8) bus(1, IDX_CTRL2, 8'(r));
            bus(1, IDX_COUNT, 8'hff);
            bus(0, IDX_PRESC, 8'h00);
            p0 = q;
            w = 20 + ($random(seed) & 63);
            bus(1, IDX_CTRL1, 8'h01);
            tick(w);
            bus(1, IDX_CTRL1, 8'h00);
            bus(0, IDX_PRESC, 8'h00);
            pn = (p0 - q) & 8'hff;
            bus(0, IDX_COUNT, 8'h00);
            dn = 8'hff - q;
            if (r < 8) chk(near(pn, w + 3, 2), 1);
            if (r < 8) chk(near(dn, pn >> (r + 1), 1), 1);
            else chk(near(dn, w + 3, 2), 1);
        end
        // External pin edges; the last rising edge is counted only on rising.
        // Port logic asks to drive the pin; the clock input must still keep it released.
        gpio_oe_i <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            bus(1, IDX_CTRL2, e ? 8'h38 : 8'h28);
            tick(1);
            chk(shared_pin_oe_o, 1'b0);
            bus(1, IDX_COUNT, 8'h40);
            bus(1, IDX_CTRL1, 8'h01);
            k = 3 + ($random(seed) & 7);
            repeat (k) begin
                shared_pin_i <= 1'b1;
                tick(3);
                shared_pin_i <= 1'b0;
                tick(3);
            end
            shared_pin_i <= 1'b1;
            tick(8);
            bus(1, IDX_CTRL1, 8'h00);
            bus(0, IDX_COUNT, 8'h00);
            chk(q, 8'(8'h40 - k - (e ? 0 : 1)));
            shared_pin_i <= 1'b0;
            tick(4);
        end
        // Pulse width over six periods of 33 counts, both polarities.
        bus(1, IDX_CTRL2, 8'h08);
        for (int p = 0; p < 2; p++) begin
            bus(1, IDX_COUNT, 8'h20);
            bus(1, IDX_DUTY, 8'h10);
            bus(1, IDX_CTRL1, p ? 8'hc3 : 8'h83);
            tick(40);
            act = 0;
            bad = 0;
            repeat (198) begin
                @(posedge clk_i);
                act += int'((pwm_o ^ p[0]) === 1'b1);
                bad += int'(shared_pin_o !== pwm_o || shared_pin_oe_o !== 1'b1);
            end
            chk(near(act, 102, 2), 1);
            chk(bad, 0);
            bus(1, IDX_CTRL1, 8'h00);
        end
        // All buzzer taps, enabled and not, with random pin option and port data.
        bus(1, IDX_COUNT, v);
        bus(0, IDX_PRESC, 8'h00);
        p0 = q;
        for (int b = 0; b < 32; b++) begin
            {buzzer_pin_option_i, gpio_out_i, gpio_oe_i} <= 3'($random(seed));
            bus(1, IDX_BUZZ, 8'({b[4], 3'h0, b[3:0]}));
            tick(3);
            ex = 8'(b[4] & (b[3] ? v[b[2:0]] : p0[b[2:0]]));
            chk(buzzer_o, ex);
            chk({shared_pin_o, shared_pin_oe_o}, (b[4] & buzzer_pin_option_i) ?
                {ex[0], 1'b1} : {gpio_out_i, gpio_oe_i});
        end
        end_sim();
    end
endmodule // testbench
